// *** src/can_fault_manager.sv ***
// fault tolerant bus line fault manager with serial diagnosis and AHB-Lite registers
//
// Summary of operation
// - faults 1,2,4,8 keep differential transmit
// - faults 1,2,5,9 keep differential receive
// - faults 3,6 use remaining line both ways
// - faults 5,9 transmit on remaining line
// - fault 7 transmits on one selected line
// - fault 10 stops transmission
// - fault 7 receives on one selected line
// - faults 4,8 receive on single line
// - fault 10 keeps normal reception
// - any fault pulls error flag low while the low power control pin is high
// - enable falling edge starts readout, ack high
// - following falling edges shift status LSB first
// - clock idle past timeout ends diagnosis
// - continued clocking restarts with ack bit
// - status bits 1-4: faults 1/5,2/9,3,4
// - status bits 5-8: faults 6,8,10,thermal
// - overtemperature disables transmitter stages
// - dominant beyond limit counts as fault 10
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module can_fault_manager
    import fault_mgr_pkg::*;
#(
    parameter int unsigned DOM_LIMIT_CYCLES = DOM_LIMIT_CYC,
    parameter int unsigned DIAG_TIMEOUT_CYCLES = DIAG_TIMEOUT_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // line fault detectors for faults 1 to 9, one level per fault
    input wire logic [8:0] line_fault_in,
    input wire logic thermal_in,
    input wire logic txd_n_in,
    input wire logic en_in,
    input wire logic low_power_ctrl_n_in,
    // path control towards the line drivers and receivers
    output logic [1:0] tx_path_out,
    output logic [1:0] rx_path_out,
    output logic tx_enable_out,
    output logic fault_flag_n_out,
    output logic irq_out
);

    // pin synchroniser positions
    localparam int unsigned SY_FAULT_LSB = 0;
    localparam int unsigned SY_THERM = 9;
    localparam int unsigned SY_TXD = 10;
    localparam int unsigned SY_EN = 11;
    localparam int unsigned SY_LPC = 12;
    localparam int unsigned SY_W = 13;

    // transmit path from the fault set; a dead line on both sides leaves nothing to drive
    function automatic line_path_t tx_path_f(input logic [9:0] f, input logic therm, input logic off,
                                             input logic sel_canl);
        logic canh_bad;
        logic canl_bad;
        canh_bad = f[2] | f[4];
        canl_bad = f[5] | f[8];
        if (therm || f[9] || off)
            tx_path_f = PATH_OFF;
        else if (f[6])
            tx_path_f = sel_canl ? PATH_CANL : PATH_CANH;
        else if (canh_bad && canl_bad)
            tx_path_f = PATH_OFF;
        else if (canh_bad)
            tx_path_f = PATH_CANL;
        else if (canl_bad)
            tx_path_f = PATH_CANH;
        else
            tx_path_f = PATH_DIFF;
    endfunction : tx_path_f

    function automatic line_path_t rx_path_f(input logic [9:0] f, input logic sel_canl);
        logic canh_bad;
        logic canl_bad;
        canh_bad = f[2] | f[7];
        canl_bad = f[3] | f[5];
        if (f[6])
            rx_path_f = sel_canl ? PATH_CANL : PATH_CANH;
        else if (canh_bad && !canl_bad)
            rx_path_f = PATH_CANL;
        else if (canl_bad && !canh_bad)
            rx_path_f = PATH_CANH;
        else
            rx_path_f = PATH_DIFF;
    endfunction : rx_path_f

    // ------------------------------------------------------------ pin inputs
    logic [SY_W-1:0] sy1_q;
    logic [SY_W-1:0] sy2_q;
    logic [SY_W-1:0] sy3_q;
    logic [SY_W-1:0] pin_q;
    logic [SY_W-1:0] sy_raw;
    logic [SY_W-1:0] sy_agree;

    assign sy_raw = {low_power_ctrl_n_in, en_in, txd_n_in, thermal_in, line_fault_in};
    assign sy_agree = ~(sy2_q ^ sy3_q);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sy1_q <= 13'h1C00;
            sy2_q <= 13'h1C00;
            sy3_q <= 13'h1C00;
        end
        else
        begin
            sy1_q <= sy_raw;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // a pin level is accepted only once the last two stages agree, which filters single glitches
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            pin_q <= 13'h1C00;
        else
            pin_q <= (sy3_q & sy_agree) | (pin_q & ~sy_agree);
    end

    // ------------------------------------------------------------ fault 10 watchdog
    logic [31:0] dom_cnt_q;
    logic fault10_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || pin_q[SY_TXD])
            dom_cnt_q <= 32'h0000_0000;
        else if (dom_cnt_q < DOM_LIMIT_CYCLES)
            dom_cnt_q <= dom_cnt_q + 32'h0000_0001;
    end

    // released once the protocol unit lets the bus go recessive again
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            fault10_q <= 1'b0;
        else
            fault10_q <= !pin_q[SY_TXD] && (dom_cnt_q >= DOM_LIMIT_CYCLES);
    end

    // ------------------------------------------------------------ fault state
    logic [9:0] faults;
    logic thermal;
    logic fault_any;
    logic [9:0] faults_prev_q;
    logic thermal_prev_q;
    logic fault_any_prev_q;
    logic [7:0] diag_word;

    assign faults = {fault10_q, pin_q[SY_FAULT_LSB +: 9]};
    assign thermal = pin_q[SY_THERM];
    assign fault_any = (|faults) | thermal;

    assign diag_word[0] = faults[0] | faults[4];
    assign diag_word[1] = faults[1] | faults[8];
    assign diag_word[2] = faults[2];
    assign diag_word[3] = faults[3];
    assign diag_word[4] = faults[5];
    assign diag_word[5] = faults[7];
    assign diag_word[6] = faults[9];
    assign diag_word[7] = thermal;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            faults_prev_q <= 10'h000;
            thermal_prev_q <= 1'b0;
            fault_any_prev_q <= 1'b0;
        end
        else
        begin
            faults_prev_q <= faults;
            thermal_prev_q <= thermal;
            fault_any_prev_q <= fault_any;
        end
    end

    // ------------------------------------------------------------ diagnosis
    logic en_prev_q;
    logic en_fall;
    logic diag_active;
    logic diag_bit;
    logic diag_start;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            en_prev_q <= 1'b1;
        else
            en_prev_q <= pin_q[SY_EN];
    end

    assign en_fall = en_prev_q && !pin_q[SY_EN];

    diag_shifter #(
        .TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES)
    ) u_diag (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .en_fall_in(en_fall),
        .status_in(diag_word),
        .active_out(diag_active),
        .bit_out(diag_bit),
        .start_out(diag_start)
    );

    // ------------------------------------------------------------ registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_ev;
    logic [7:0] diag_last_q;
    logic [7:0] fault_cnt_q;
    logic [7:0] wr_addr_q;
    logic wr_pend_q;
    logic addr_phase;
    logic rd_irq_stat;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign addr_phase = hsel_in && htrans_in[1] && hready_in;
    assign rd_irq_stat = addr_phase && !hwrite_in && (haddr_in[7:0] == ADDR_IRQ_STAT);

    assign status_word = {15'h0000, fault_flag_n_out, rx_path_out, tx_path_out, diag_active, thermal,
                          faults};

    always_comb
    begin
        case (haddr_in[7:0])
            ADDR_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
            ADDR_STATUS: rd_mux = status_word;
            ADDR_IRQ_STAT: rd_mux = {27'h000_0000, irq_stat_q};
            ADDR_IRQ_MASK: rd_mux = {27'h000_0000, irq_mask_q};
            ADDR_DIAG_WORD: rd_mux = {24'h00_0000, diag_last_q};
            ADDR_FAULT_CNT: rd_mux = {24'h00_0000, fault_cnt_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // zero wait state slave: read data is registered at the address phase edge
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            hrdata_out <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
        else
        begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (addr_phase && !hwrite_in)
                hrdata_out <= rd_mux;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite_in;
            if (addr_phase)
                wr_addr_q <= haddr_in[7:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= IRQ_MASK_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == ADDR_CTRL)
                ctrl_q <= hwdata_in[CTRL_W-1:0];
            if (wr_addr_q == ADDR_IRQ_MASK)
                irq_mask_q <= hwdata_in[IRQ_W-1:0];
        end
    end

    // word captured when a readout starts from idle, kept for software after the readout ends
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            diag_last_q <= 8'h00;
        else if (diag_start)
            diag_last_q <= diag_word;
    end

    // onset count saturates rather than wraps so a busy bus never reads as quiet
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            fault_cnt_q <= 8'h00;
        else if (fault_any && !fault_any_prev_q && fault_cnt_q != 8'hFF)
            fault_cnt_q <= fault_cnt_q + 8'h01;
    end

    // ------------------------------------------------------------ interrupts
    always_comb
    begin
        irq_ev = '0;
        irq_ev[IRQ_FAULT_SET_BIT] = |(faults & ~faults_prev_q) || (thermal && !thermal_prev_q);
        irq_ev[IRQ_FAULT_CLR_BIT] = fault_any_prev_q && !fault_any;
        irq_ev[IRQ_FAULT10_BIT] = faults[9] && !faults_prev_q[9];
        irq_ev[IRQ_THERMAL_BIT] = thermal && !thermal_prev_q;
        irq_ev[IRQ_DIAG_BIT] = diag_start;
        // an event in the clearing cycle survives the read
        irq_stat_d = (rd_irq_stat ? '0 : irq_stat_q) | irq_ev;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            irq_stat_q <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_out <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------ line paths and error flag
    logic mode_active;

    // normal and receive-only both keep the low power control pin high
    assign mode_active = pin_q[SY_LPC];

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            tx_path_out <= PATH_DIFF;
            rx_path_out <= PATH_DIFF;
            tx_enable_out <= 1'b1;
        end
        else
        begin
            tx_path_out <= tx_path_f(faults, thermal, ctrl_q[CTRL_TX_OFF_BIT], ctrl_q[CTRL_F7_CANL_BIT]);
            rx_path_out <= rx_path_f(faults, ctrl_q[CTRL_F7_CANL_BIT]);
            tx_enable_out <= (tx_path_f(faults, thermal, ctrl_q[CTRL_TX_OFF_BIT],
                              ctrl_q[CTRL_F7_CANL_BIT]) != PATH_OFF);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            fault_flag_n_out <= 1'b1;
        else if (diag_active)
            fault_flag_n_out <= diag_bit;
        else
            fault_flag_n_out <= !(mode_active && fault_any);
    end

endmodule : can_fault_manager
`default_nettype wire

// *** pkg/fault_mgr_pkg.sv ***
// constants, register map and types shared by the bus fault manager design
package fault_mgr_pkg;

    // clock and timing
    localparam int unsigned CLK_FREQ_HZ = 20_000_000;
    localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
    // protocol unit dominant limit, 1.3 ms, held in microseconds
    localparam int unsigned DOM_LIMIT_US = 1300;
    localparam int unsigned DOM_LIMIT_CYC = DOM_LIMIT_US * CYC_PER_US;
    // diagnosis idle timeout; the value is a plain default
    localparam int unsigned DIAG_TIMEOUT_US = 100;
    localparam int unsigned DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * CYC_PER_US;

    // fault vector: bit n-1 holds line fault n, for faults 1 to 10
    localparam int unsigned FAULT_W = 10;
    localparam int unsigned DIAG_W = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_DIAG_WORD = 8'h10;
    localparam logic [7:0] ADDR_FAULT_CNT = 8'h14;

    // control register fields
    localparam int unsigned CTRL_F7_CANL_BIT = 0;
    localparam int unsigned CTRL_TX_OFF_BIT = 1;
    localparam int unsigned CTRL_W = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // status register fields
    localparam int unsigned STAT_FAULT_LSB = 0;
    localparam int unsigned STAT_THERMAL_BIT = 10;
    localparam int unsigned STAT_DIAG_BIT = 11;
    localparam int unsigned STAT_TXPATH_LSB = 12;
    localparam int unsigned STAT_RXPATH_LSB = 14;
    localparam int unsigned STAT_FLAG_BIT = 16;

    // interrupt status and mask fields
    localparam int unsigned IRQ_FAULT_SET_BIT = 0;
    localparam int unsigned IRQ_FAULT_CLR_BIT = 1;
    localparam int unsigned IRQ_FAULT10_BIT = 2;
    localparam int unsigned IRQ_THERMAL_BIT = 3;
    localparam int unsigned IRQ_DIAG_BIT = 4;
    localparam int unsigned IRQ_W = 5;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    // line path selection for transmitter and receiver
    typedef enum logic [1:0] {
        PATH_DIFF,
        PATH_CANH,
        PATH_CANL,
        PATH_OFF
    } line_path_t;

endpackage : fault_mgr_pkg

// *** src/diag_shifter.sv ***
// serial diagnostic readout engine clocked by falling edges of the enable pin
`timescale 1ns/10ps
`default_nettype none
module diag_shifter
    import fault_mgr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = DIAG_TIMEOUT_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_fall_in,
    input wire logic [7:0] status_in,
    output logic active_out,
    output logic bit_out,
    output logic start_out
);

    typedef enum logic [1:0] {
        DG_IDLE,
        DG_ACK,
        DG_BITS
    } diag_state_t;

    diag_state_t state_q;
    logic [7:0] word_q;
    logic [2:0] idx_q;
    logic [31:0] idle_cnt_q;
    logic timeout;

    assign timeout = (state_q != DG_IDLE) && !en_fall_in && (idle_cnt_q >= TIMEOUT_CYCLES - 1);

    // idle time since the last falling edge
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || en_fall_in || state_q == DG_IDLE)
            idle_cnt_q <= 32'h0000_0000;
        else
            idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= DG_IDLE;
            word_q <= 8'h00;
            idx_q <= 3'h0;
            bit_out <= 1'b0;
            start_out <= 1'b0;
        end
        else
        begin
            start_out <= 1'b0;
            if (timeout)
            begin
                state_q <= DG_IDLE;
                bit_out <= 1'b0;
            end
            else if (en_fall_in)
            begin
                case (state_q)
                    DG_IDLE:
                    begin
                        // snapshot so the word cannot change under the reader
                        state_q <= DG_ACK;
                        word_q <= status_in;
                        bit_out <= 1'b1;
                        start_out <= 1'b1;
                    end
                    DG_ACK:
                    begin
                        state_q <= DG_BITS;
                        idx_q <= 3'h0;
                        bit_out <= word_q[0];
                    end
                    DG_BITS:
                    begin
                        if (idx_q == 3'h7)
                        begin
                            state_q <= DG_ACK;
                            word_q <= status_in;
                            bit_out <= 1'b1;
                        end
                        else
                        begin
                            idx_q <= idx_q + 3'h1;
                            bit_out <= word_q[idx_q + 3'h1];
                        end
                    end
                    default:
                    begin
                        state_q <= DG_IDLE;
                        bit_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign active_out = (state_q != DG_IDLE);

endmodule : diag_shifter
`default_nettype wire

// *** verification/can_fault_manager_assertions.sv ***
// concurrent checks on the fault manager ports
`timescale 1ns/10ps
`default_nettype none
module can_fault_manager_assertions
    import fault_mgr_pkg::*;
#(
    parameter int unsigned DOM_LIMIT_CYCLES = DOM_LIMIT_CYC,
    parameter int unsigned DIAG_TIMEOUT_CYCLES = DIAG_TIMEOUT_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [8:0] line_fault_in,
    input wire logic thermal_in,
    input wire logic txd_n_in,
    input wire logic en_in,
    input wire logic low_power_ctrl_n_in,
    input wire logic [1:0] tx_path_out,
    input wire logic [1:0] rx_path_out,
    input wire logic tx_enable_out,
    input wire logic fault_flag_n_out
);
    int unsigned dom_cnt_q;
    int unsigned idle_cnt_q;
    logic en_prev_q;
    logic idle_long;
    // margins cover the input synchronisers, so checks fire only on settled inputs
    assign idle_long = idle_cnt_q > DIAG_TIMEOUT_CYCLES + 20;
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || txd_n_in) dom_cnt_q <= 0;
        else if (dom_cnt_q < DOM_LIMIT_CYCLES + 20) dom_cnt_q <= dom_cnt_q + 1;
    end
    always_ff @(posedge clk_in)
    begin
        en_prev_q <= en_in;
        if (!rst_n_in || en_in != en_prev_q) idle_cnt_q <= 0;
        else if (idle_cnt_q < DIAG_TIMEOUT_CYCLES + 40) idle_cnt_q <= idle_cnt_q + 1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_thermal_off;
        thermal_in [*8] |-> !tx_enable_out && tx_path_out == PATH_OFF;
    endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("tx on in overtemperature");
    property p_dom_off;
        (dom_cnt_q >= DOM_LIMIT_CYCLES + 10 && line_fault_in == 9'h000) [*8] |->
            !tx_enable_out && rx_path_out == PATH_DIFF;
    endproperty
    a_dom_off: assert property (p_dom_off) else $error("stuck dominant not handled");
    property p_flag_low;
        (idle_long && low_power_ctrl_n_in && line_fault_in != 9'h000) [*8] |-> !fault_flag_n_out;
    endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag high with fault");
    property p_flag_free;
        (idle_long && line_fault_in == 9'h000 && !thermal_in && txd_n_in) [*8] |-> fault_flag_n_out;
    endproperty
    a_flag_free: assert property (p_flag_free) else $error("flag low without fault");
    property p_ack;
        (idle_long && $fell(en_in)) ##1 (!en_in) [*8] |-> fault_flag_n_out;
    endproperty
    a_ack: assert property (p_ack) else $error("readout not acknowledged");
    property p_single;
        (line_fault_in == 9'h004) [*8] |-> rx_path_out == PATH_CANL && (tx_path_out == PATH_CANL || !tx_enable_out);
    endproperty
    a_single: assert property (p_single) else $error("no single wire path");
    property p_negl;
        (line_fault_in == 9'h001 || line_fault_in == 9'h002) [*8] |->
            rx_path_out == PATH_DIFF && (tx_path_out == PATH_DIFF || !tx_enable_out);
    endproperty
    a_negl: assert property (p_negl) else $error("diff path lost");
    property p_short;
        (line_fault_in == 9'h040) [*8] |->
            rx_path_out inside {PATH_CANH, PATH_CANL} && (tx_path_out == rx_path_out || !tx_enable_out);
    endproperty
    a_short: assert property (p_short) else $error("shorted lines path wrong");
    property p_gnd;
        (line_fault_in == 9'h010) [*8] |-> rx_path_out == PATH_DIFF && (tx_path_out == PATH_CANL || !tx_enable_out);
    endproperty
    a_gnd: assert property (p_gnd) else $error("short path wrong");
endmodule : can_fault_manager_assertions
bind can_fault_manager can_fault_manager_assertions #(.DOM_LIMIT_CYCLES(DOM_LIMIT_CYCLES),
    .DIAG_TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES)) u_can_fault_manager_assertions (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .line_fault_in(line_fault_in), .thermal_in(thermal_in), .txd_n_in(txd_n_in),
    .en_in(en_in), .low_power_ctrl_n_in(low_power_ctrl_n_in), .tx_path_out(tx_path_out),
    .rx_path_out(rx_path_out), .tx_enable_out(tx_enable_out), .fault_flag_n_out(fault_flag_n_out));
`default_nettype wire

// *** verification/diag_master_model.sv ***
// local controller model that clocks the diagnostic word out
`timescale 1ns/10ps
`default_nettype none
module diag_master_model
(
    input wire logic clk_in,
    input wire logic fault_flag_n_in,
    output logic en_out
);
    initial en_out = 1'b1;
    // sampled just before the next fall, so the flag has long settled
    task automatic clock_falls(input int n, input int half, output logic [31:0] bits);
        bits = 32'h0000_0000;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            en_out <= 1'b0;
            repeat (half) @(posedge clk_in);
            en_out <= 1'b1;
            repeat (half - 1) @(posedge clk_in);
            bits[i] = fault_flag_n_in;
        end
    endtask : clock_falls
endmodule : diag_master_model
`default_nettype wire

// *** verification/can_bus_fault_manager_diag_tb.sv ***
// self-checking testbench for the bus fault manager
`timescale 1ns/10ps
`default_nettype none
module can_bus_fault_manager_diag_tb;
    import fault_mgr_pkg::*;
    localparam int unsigned DOM_LIM = 50;
    localparam int unsigned DIAG_TO = 40;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic [8:0] line_fault_in = 9'h000;
    logic thermal_in = 1'b0;
    logic txd_n_in = 1'b1;
    logic lpc_n_in = 1'b1;
    logic en_w;
    logic [31:0] hrdata_out;
    logic hreadyout_out;
    logic hresp_out;
    logic [1:0] tx_path_out;
    logic [1:0] rx_path_out;
    logic tx_enable_out;
    logic fault_flag_n_out;
    logic irq_out;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [31:0] bits;
    // {tx, rx} path for single faults 1 to 9
    logic [3:0] path_tab [9] = '{4'h0, 4'h0, 4'hA, 4'h1, 4'h8, 4'h5, 4'h5, 4'h2, 4'h4};
    always #25 clk_in = ~clk_in;
    can_fault_manager #(.DOM_LIMIT_CYCLES(DOM_LIM), .DIAG_TIMEOUT_CYCLES(DIAG_TO)) u_can_fault_manager (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .line_fault_in(line_fault_in), .thermal_in(thermal_in), .txd_n_in(txd_n_in), .en_in(en_w),
        .low_power_ctrl_n_in(lpc_n_in), .tx_path_out(tx_path_out), .rx_path_out(rx_path_out),
        .tx_enable_out(tx_enable_out), .fault_flag_n_out(fault_flag_n_out), .irq_out(irq_out));
    diag_master_model u_diag_master_model (.clk_in(clk_in), .fault_flag_n_in(fault_flag_n_out), .en_out(en_w));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, addr};
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask : ahb_xfer
    task automatic check_reg(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
        ahb_xfer(1'b0, addr, 32'h0);
        chk(rd & mask, exp);
    endtask : check_reg
    task automatic set_pins(input logic [8:0] f, input logic th, input logic txd_n, input int n);
        @(posedge clk_in);
        line_fault_in <= f;
        thermal_in <= th;
        txd_n_in <= txd_n;
        repeat (n) @(posedge clk_in);
    endtask : set_pins
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        check_reg(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
        ahb_xfer(1'b1, ADDR_IRQ_MASK, 32'h0000_001F);
        check_reg(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_001F);
        check_reg(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        chk({30'h0, hreadyout_out, hresp_out}, 32'h2);
        ahb_xfer(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
        $display("test registers done");
        for (int i = 0; i < 9; i++)
        begin
            set_pins(9'(1 << i), 1'b0, 1'b1, 10);
            chk({31'h0, fault_flag_n_out}, 32'h0);
            check_reg(ADDR_STATUS, 32'hFFFF_FFFF,
                      {16'h0, path_tab[i][1:0], path_tab[i][3:2], 2'h0, 10'(1 << i)});
            chk({31'h0, irq_out}, 32'h1);
            check_reg(ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
            set_pins(9'h000, 1'b0, 1'b1, 10);
            chk({31'h0, irq_out}, 32'h0);
        end
        ahb_xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
        set_pins(9'h040, 1'b0, 1'b1, 10);
        check_reg(ADDR_STATUS, 32'h0000_F000, 32'h0000_A000);
        lpc_n_in <= 1'b0;
        ahb_xfer(1'b1, ADDR_CTRL, 32'h0000_0002);
        repeat (8) @(posedge clk_in);
        chk({30'h0, tx_enable_out, fault_flag_n_out}, 32'h1);
        lpc_n_in <= 1'b1;
        ahb_xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
        set_pins(9'h000, 1'b0, 1'b1, 10);
        $display("test paths done");
        ahb_xfer(1'b1, ADDR_IRQ_MASK, 32'h0000_0004);
        set_pins(9'h000, 1'b0, 1'b0, DOM_LIM - 10);
        chk({31'h0, tx_enable_out}, 32'h1);
        repeat (25) @(posedge clk_in);
        chk({28'h0, tx_enable_out, rx_path_out, irq_out}, 32'h1);
        check_reg(ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
        chk({31'h0, irq_out}, 32'h0);
        $display("test stuck dominant done");
        // thermal and stuck dominant stay on so the word has its top bits set
        set_pins(9'h081, 1'b1, 1'b0, 10);
        chk({30'h0, tx_enable_out, fault_flag_n_out}, 32'h0);
        u_diag_master_model.clock_falls(19, 12, bits);
        chk(bits, 32'h0007_87C3);
        repeat (DIAG_TO + 30) @(posedge clk_in);
        chk({31'h0, fault_flag_n_out}, 32'h0);
        check_reg(ADDR_STATUS, 32'h0000_0800, 32'h0000_0000);
        check_reg(ADDR_DIAG_WORD, 32'hFFFF_FFFF, 32'h0000_00E1);
        set_pins(9'h000, 1'b0, 1'b1, 10);
        chk({30'h0, tx_enable_out, fault_flag_n_out}, 32'h3);
        check_reg(ADDR_FAULT_CNT, 32'hFFFF_FFFF, 32'h0000_000B);
        $display("test diagnosis done");
        print_verdict();
    end
endmodule : can_bus_fault_manager_diag_tb
`default_nettype wire
